/* File: hw/intranet_header_pkg.sv */
package intranet_header_pkg;
  localparam int OCTET_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int HDR_OCTETS = 3;
  // field widths and bit positions within the packed header word
  localparam int VER_W = 4;
  localparam int MSG_W = 4;
  localparam int HLEN_W = 8;
  localparam int TOS_W = 8;
  localparam int VER_POS = 0;
  localparam int MSG_POS = 4;
  localparam int HLEN_POS = 8;
  localparam int TOS_POS = 16;
  localparam int HDR_W = 24;
  localparam logic [1:0] FIRST_OCTET = 2'h0;
  localparam logic [1:0] LAST_OCTET = 2'h2;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [OCTET_W-1:0] OCTET_RESET = 8'h00;
endpackage

/* File: hw/octet_fifo.sv */
`timescale 1ns/1ps
module octet_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // sync reset, active low
  input wire logic clkEn, // freezes state when low
  input wire logic inValid, // write request
  output logic inReady, // not full
  input wire logic [WIDTH-1:0] inData, // write data
  output logic outValid, // not empty
  input wire logic outReady, // read request
  output logic [WIDTH-1:0] outData // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0] count_reg, count_next;
  logic doWr, doRd;

  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign doWr = clkEn && inValid && inReady;
  assign doRd = clkEn && outValid && outReady;

  always_comb begin
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (doWr) begin
      wrPtr_next = wrPtr_reg + 1'b1;
    end
    if (doRd) begin
      rdPtr_next = rdPtr_reg + 1'b1;
    end
    if (doWr && !doRd) begin
      count_next = count_reg + 1'b1;
    end else if (doRd && !doWr) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr_reg] <= inData;
    end
  end
endmodule // octet_fifo

/* File: hw/intranet_header_packer.sv */
// Function
// - field lsb into lowest free octet bit
// - overflowing field bits continue next octet
// - fields and octets packed in order
// - octets numbered from zero upward
// - version, type, length, service layout
// - example fields give 40h,03h,00h
// - octets sent lsb first, payload follows
`timescale 1ns/1ps
module intranet_header_packer
  import intranet_header_pkg::*;
(
  input wire logic sys_clk, // 100 MHz clock
  input wire logic rst_n, // sync reset, active low
  input wire logic clkEn, // freezes all state when low
  input wire logic hdrStart, // pulse: take fields, build header
  input wire logic [VER_W-1:0] verNum, // version field
  input wire logic [MSG_W-1:0] msgType, // message type field
  input wire logic [HLEN_W-1:0] hdrLen, // header length field
  input wire logic [TOS_W-1:0] svcType, // service type field
  output logic hdrBusy, // frame being packed, header through last payload octet
  input wire logic payValid, // payload octet valid
  output logic payReady, // payload octet taken
  input wire logic [OCTET_W-1:0] payData, // payload (ip header) octet
  input wire logic payLast, // last payload octet
  output logic octValid, // octet stream valid to framer
  input wire logic octReady, // framer ready
  output logic [OCTET_W-1:0] octData, // octet to framer
  output logic [1:0] octNum, // header octet number
  output logic serBit, // serial bit, lsb first
  output logic serValid // serial bit valid
);
  typedef enum {IDLE, PACK, PAYLOAD} state_e;
  state_e state_reg, state_next;
  logic [HDR_W-1:0] hdrWord_reg, hdrWord_next;
  logic [1:0] octIdx_reg, octIdx_next;
  logic fifoReady, fifoInValid, fifoOutValid;
  logic [OCTET_W-1:0] fifoInData, fifoOutData;
  logic busy_reg, payReady_reg, payReady_next;
  logic [OCTET_W-1:0] shift_reg, shift_next;
  logic [2:0] bitIdx_reg, bitIdx_next;
  logic shifting_reg, shifting_next, serBit_reg, serValid_reg;
  logic [1:0] num_reg, num_next;
  logic fifoPop, octVal_reg;
  logic [OCTET_W-1:0] octData_reg;

  // fields concatenated lsb upward so bit slices fall into octets in order
  function automatic logic [HDR_W-1:0] packFields(input logic [VER_W-1:0] v,
      input logic [MSG_W-1:0] m, input logic [HLEN_W-1:0] l, input logic [TOS_W-1:0] t);
    logic [HDR_W-1:0] w;
    w = '0;
    w[VER_POS +: VER_W] = v;
    w[MSG_POS +: MSG_W] = m;
    w[HLEN_POS +: HLEN_W] = l;
    w[TOS_POS +: TOS_W] = t;
    return w;
  endfunction

  // header and payload share one path so payload follows header with no gap
  always_comb begin
    state_next = state_reg;
    hdrWord_next = hdrWord_reg;
    octIdx_next = octIdx_reg;
    fifoInValid = 1'b0;
    fifoInData = OCTET_RESET;
    case (state_reg)
      IDLE: begin
        if (hdrStart) begin
          hdrWord_next = packFields(verNum, msgType, hdrLen, svcType);
          octIdx_next = FIRST_OCTET;
          state_next = PACK;
        end
      end
      PACK: begin
        fifoInValid = 1'b1;
        fifoInData = hdrWord_reg[OCTET_W-1:0];
        if (fifoReady) begin
          hdrWord_next = hdrWord_reg >> OCTET_W;
          octIdx_next = octIdx_reg + 2'h1;
          if (octIdx_reg == LAST_OCTET) begin
            state_next = PAYLOAD;
          end
        end
      end
      PAYLOAD: begin
        // only an octet offered under our own ready is written, so none is taken twice
        fifoInValid = payValid && payReady_reg;
        fifoInData = payData;
        if (payValid && payReady_reg && payLast) begin
          state_next = IDLE;
        end
      end
      default: state_next = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= IDLE;
      hdrWord_reg <= '0;
      octIdx_reg <= FIRST_OCTET;
      busy_reg <= 1'b0;
      payReady_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      hdrWord_reg <= hdrWord_next;
      octIdx_reg <= octIdx_next;
      busy_reg <= (state_next != IDLE);
      payReady_reg <= payReady_next;
    end
  end
  // registered ready promises room one cycle ahead; a write without a pop may fill
  // the last slot, so ready is held back then at the cost of some throughput
  assign payReady_next = (state_next == PAYLOAD) && fifoReady && (!fifoInValid || fifoPop);

  octet_fifo #(.WIDTH(OCTET_W), .DEPTH(FIFO_DEPTH)) octet_fifo_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .inValid(fifoInValid),
    .inReady(fifoReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  // output stage: one registered octet slot, refilled when framer takes it
  assign fifoPop = fifoOutValid && (!octVal_reg || octReady);

  always_comb begin
    num_next = num_reg;
    shift_next = shift_reg;
    bitIdx_next = bitIdx_reg;
    shifting_next = shifting_reg;
    if (octVal_reg && octReady) begin
      num_next = num_reg + 2'h1;
      shift_next = octData_reg;
      bitIdx_next = FIRST_BIT;
      shifting_next = 1'b1;
    end else if (shifting_reg) begin
      shift_next = shift_reg >> 1;
      bitIdx_next = bitIdx_reg + 3'h1;
      if (bitIdx_reg == LAST_BIT) begin
        shifting_next = 1'b0;
      end
    end
    if (state_reg == IDLE && hdrStart) begin
      num_next = FIRST_OCTET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      octVal_reg <= 1'b0;
      octData_reg <= OCTET_RESET;
      num_reg <= FIRST_OCTET;
      shift_reg <= OCTET_RESET;
      bitIdx_reg <= FIRST_BIT;
      shifting_reg <= 1'b0;
      serBit_reg <= 1'b0;
      serValid_reg <= 1'b0;
    end else if (clkEn) begin
      if (fifoPop) begin
        octVal_reg <= 1'b1;
        octData_reg <= fifoOutData;
      end else if (octReady) begin
        octVal_reg <= 1'b0;
      end
      num_reg <= num_next;
      shift_reg <= shift_next;
      bitIdx_reg <= bitIdx_next;
      shifting_reg <= shifting_next;
      serBit_reg <= shift_next[0];
      serValid_reg <= shifting_next;
    end
  end

  assign hdrBusy = busy_reg;
  assign payReady = payReady_reg;
  assign octValid = octVal_reg;
  assign octData = octData_reg;
  assign octNum = num_reg;
  assign serBit = serBit_reg;
  assign serValid = serValid_reg;

  // serial view only keeps pace when framer ready is not faster than 1 per 8 cycles

  holdValid_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    octVal_reg && !octReady && clkEn |=> octVal_reg && $stable(octData_reg))
    else $error("octet dropped before handshake");
  payRoom_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    payValid && payReady_reg && clkEn |-> fifoReady)
    else $error("payload octet taken without fifo room");
  packOrder_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == PACK && fifoReady && clkEn |=> hdrWord_reg == $past(hdrWord_reg) >> OCTET_W)
    else $error("header octets not shifted in order");
  firstOct_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == IDLE && hdrStart && clkEn |=> octIdx_reg == FIRST_OCTET)
    else $error("header numbering not from zero");
  fieldPlace_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == IDLE && hdrStart && clkEn |=> hdrWord_reg[MSG_POS+:MSG_W] == $past(msgType)
      && hdrWord_reg[VER_POS+:VER_W] == $past(verNum))
    else $error("octet zero nibbles misplaced");
  fieldCarry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == IDLE && hdrStart && clkEn |=> hdrWord_reg[TOS_POS+:TOS_W] == $past(svcType)
      && hdrWord_reg[HLEN_POS+:HLEN_W] == $past(hdrLen))
    else $error("later octets misplaced");
  example_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == IDLE && hdrStart && clkEn && verNum == 4'h0 && msgType == 4'h4
      && hdrLen == 8'h03 && svcType == 8'h00 |=> hdrWord_reg == 24'h000340)
    else $error("example header wrong");
  payFollow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == PACK && octIdx_reg == LAST_OCTET && fifoReady && clkEn |=> state_reg == PAYLOAD)
    else $error("payload does not follow header");
  lsbFirst_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    octVal_reg && octReady && clkEn |=> serValid_reg && serBit_reg == $past(octData_reg[0]))
    else $error("serial not lsb first");
  headerDone_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == PACK ##1 state_reg == PAYLOAD);
  stall_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    octVal_reg && !octReady [*3]);
  fifoFull_c: cover property (@(posedge sys_clk) disable iff (!rst_n) !fifoReady);
endmodule // intranet_header_packer

/* File: dv/framer_sink.sv */
`timescale 1ns/1ps
module framer_sink (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // sync reset, active low
  input wire logic octValid, // octet offered
  input wire logic [7:0] octData, // offered octet
  output logic octReady, // octet taken on this edge
  input wire logic [7:0] gap, // idle cycles between ready pulses
  input wire logic hold // stalls ready entirely
);
  logic [7:0] cntReg;
  // information field as received
  logic [7:0] got[$];

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      cntReg <= 8'h00;
      octReady <= 1'b0;
    end else begin
      if (octValid && octReady) begin
        got.push_back(octData);
      end
      // ready pulses spaced by gap, so slow and prompt framers share one model
      cntReg <= (cntReg >= gap) ? 8'h00 : cntReg + 8'h01;
      octReady <= !hold && (cntReg >= gap);
    end
  end
endmodule // framer_sink

/* File: dv/intranet_header_packer_tb.sv */
`timescale 1ns/1ps
module intranet_header_packer_tb;
  import intranet_header_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, hdrStart = 1'b0, payValid = 1'b0, payLast = 1'b0;
  logic hold = 1'b0, hdrBusy, payReady, octValid, octReady, serBit, serValid;
  logic [3:0] verNum = 4'h0, msgType = 4'h0;
  logic [7:0] hdrLen = 8'h00, svcType = 8'h00, payData = 8'h00, gap = 8'h00;
  logic [7:0] octData, serAcc;
  logic [1:0] octNum;
  logic [7:0] serQ[$];
  logic [1:0] numQ[$];
  int error_cnt = 0, samples_checked = 0, serCnt = 0;

  intranet_header_packer intranet_header_packer_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEn(1'b1), .hdrStart(hdrStart), .verNum(verNum), .msgType(msgType), .hdrLen(hdrLen),
    .svcType(svcType), .hdrBusy(hdrBusy), .payValid(payValid), .payReady(payReady),
    .payData(payData), .payLast(payLast), .octValid(octValid), .octReady(octReady),
    .octData(octData), .octNum(octNum), .serBit(serBit), .serValid(serValid));
  framer_sink framer_sink_i (.sys_clk(sys_clk), .rst_n(rst_n), .octValid(octValid),
    .octData(octData), .octReady(octReady), .gap(gap), .hold(hold));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (octValid === 1'b1 && octReady === 1'b1) numQ.push_back(octNum);
    if (serValid === 1'b1) begin
      serAcc[serCnt[2:0]] = serBit;
      serCnt++;
      if (serCnt == 8) begin
        serQ.push_back(serAcc);
        serCnt = 0;
      end
    end
  end

  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout();
    error_cnt++;
    end_of_test();
  endtask

  // dup issues a second start with other fields while busy; it must be ignored
  task automatic send_frame(logic [3:0] v, m, logic [7:0] l, s, int n, bit dup);
    int k;
    framer_sink_i.got.delete();
    numQ.delete();
    @(posedge sys_clk) #1;
    hdrStart = 1'b1;
    {verNum, msgType, hdrLen, svcType} = {v, m, l, s};
    @(posedge sys_clk) #1;
    hdrStart = dup;
    {verNum, hdrLen} = {~v, ~l};
    check("busy during frame", {7'h00, hdrBusy}, 8'h01);
    @(posedge sys_clk) #1;
    hdrStart = 1'b0;
    for (int i = 0; i < n; i++) begin
      payValid = 1'b1;
      payData = 8'hA0 + i[7:0];
      payLast = (i == n - 1);
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
      end while (payReady !== 1'b1 && k < 2000);
      if (k >= 2000) timeout();
      #1;
    end
    payValid = 1'b0;
    payLast = 1'b0;
    k = 0;
    while (framer_sink_i.got.size() < n + 3 && k < 5000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 5000) timeout();
    repeat (20) @(posedge sys_clk);
    check("octet count", 8'(framer_sink_i.got.size()), 8'(n + 3));
    check("busy after frame", {7'h00, hdrBusy}, 8'h00);
    check("octet0", framer_sink_i.got[0], {m, v});
    check("octet1", framer_sink_i.got[1], l);
    check("octet2", framer_sink_i.got[2], s);
    for (int i = 0; i < 3; i++) check("octNum", {6'h00, numQ[i]}, 8'(i));
    for (int i = 0; i < n; i++) check("payload", framer_sink_i.got[3 + i], 8'hA0 + i[7:0]);
  endtask

  task automatic test_example();
    send_frame(4'h0, 4'h4, 8'h03, 8'h00, 4, 1'b0);
    check("example0", framer_sink_i.got[0], 8'h40);
    check("example1", framer_sink_i.got[1], 8'h03);
    check("example2", framer_sink_i.got[2], 8'h00);
  endtask

  task automatic test_fields();
    send_frame(4'hF, 4'h0, 8'hA5, 8'h5A, 1, 1'b1);
  endtask

  task automatic test_fill();
    #1 hold = 1'b1;
    fork
      send_frame(4'h9, 4'h6, 8'h81, 8'h7E, 40, 1'b0);
      begin
        repeat (300) @(posedge sys_clk);
        check("full refusal", {6'h00, payValid, payReady}, 8'h02);
        #1 hold = 1'b0;
      end
    join
  endtask

  task automatic test_serial();
    @(posedge sys_clk) #1;
    gap = 8'h0C;
    serCnt = 0;
    serQ.delete();
    send_frame(4'h0, 4'h4, 8'h03, 8'h00, 2, 1'b0);
    for (int i = 0; i < 5; i++) check("serial octet", serQ[i], framer_sink_i.got[i]);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    test_example();
    test_fields();
    test_fill();
    test_serial();
    end_of_test();
  end
endmodule // intranet_header_packer_tb
